//--- cbm_pkg.sv
// package for the crt beam measurement control block
// assumes a 25 MHz system clock; shared by all three design files
package cbm_pkg;
   // ==========================================================
   // timing
   localparam int          CLK_MHZ          = 25;
   localparam int          WIN_SMALL_BW_NS  = 19000;   // small bandwidth window
   localparam int          WIN_LARGE_BW_NS  = 9500;    // large bandwidth window
   localparam int          WIN_SMALL_BW_CYC = (WIN_SMALL_BW_NS * CLK_MHZ + 999) / 1000;
   localparam int          WIN_LARGE_BW_CYC = (WIN_LARGE_BW_NS * CLK_MHZ + 999) / 1000;
   localparam int          ABL_BW_HZ        = 2000;
   // first-order iir shift giving roughly 2 kHz corner at one update per sample
   localparam int          ABL_SHIFT        = 11;
   // ==========================================================
   // line offsets inside the tube sequence
   localparam logic [9:0]  RED_CUT_OFS      = 10'h002;
   localparam logic [9:0]  RECOVER_LINES    = 10'h003;
   // ==========================================================
   // widths
   localparam int          RES_W            = 8;
   localparam int          CUT_W            = 9;
   localparam int          RGB_W            = 10;
   localparam int          ATT_W            = 8;
   localparam logic [ATT_W-1:0] ATT_UNITY   = 8'hff;
   localparam int          PDM_ACC_W        = 9;
   // ==========================================================
   // tube and picture sequence states
   typedef enum logic [2:0] {
      TS_IDLE, TS_WAIT, TS_OFFSET, TS_CUT_R, TS_CUT_G, TS_CUT_B, TS_WHITE, TS_RECOVER
   } cbm_tube_st_t;
   typedef enum logic [1:0] {
      PS_IDLE, PS_ARMED, PS_RUN
   } cbm_pic_st_t;
endpackage : cbm_pkg

//--- cbm_pdm_conv.sv
// pulse-density measurement converter: counts ones of the sense bit stream
// assumes pdm_bit synchronous to clk_sys; window length set by the caller
`timescale 1ns/10ps
`default_nettype none
module cbm_pdm_conv
   import cbm_pkg::*;
#(
   parameter int WIN_SMALL = WIN_SMALL_BW_CYC,
   parameter int WIN_LARGE = WIN_LARGE_BW_CYC
) (
   input  wire logic             clk_sys,  // system clock
   input  wire logic             rst,      // async reset
   input  wire logic             clk_en,   // freeze when low
   input  wire logic             pdm_bit,  // sense bit stream
   input  wire logic             start,    // start a window
   input  wire logic             bw_large, // 1 selects large bandwidth
   output logic                  done,     // one-cycle result strobe
   output logic [RES_W-1:0]      result    // 8-bit result
);
   localparam int CW = 10;
   logic [CW-1:0] cnt_q;
   logic [CW-1:0] len_q;
   logic [CW-1:0] ones_q;
   logic          busy_q;
   logic [CW+RES_W-1:0] scaled;

   // =========================================================
   // window and ones count
   assign scaled = {(RES_W)'(0), ones_q} * (CW+RES_W)'(2**RES_W - 1);

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         cnt_q  <= '0;
         len_q  <= '0;
         ones_q <= '0;
         busy_q <= 1'b0;
         done   <= 1'b0;
         result <= '0;
      end else if (clk_en) begin
         done <= 1'b0;
         if (start) begin
            busy_q <= 1'b1;
            cnt_q  <= '0;
            ones_q <= '0;
            len_q  <= bw_large ? CW'(WIN_LARGE) : CW'(WIN_SMALL);
         end else if (busy_q) begin
            ones_q <= ones_q + CW'(pdm_bit);
            cnt_q  <= cnt_q + 1'b1;
            if (cnt_q == len_q - 1'b1) begin
               busy_q <= 1'b0;
               done   <= 1'b1;
               // normalise ones over window to full 8-bit scale
               result <= RES_W'(scaled / (CW+RES_W)'(len_q));
            end
         end
      end
   end
endmodule : cbm_pdm_conv
`default_nettype wire

//--- cbm_res_reg.sv
// result holding register: keeps last completed value until next load
// assumes one-cycle load strobe
`timescale 1ns/10ps
`default_nettype none
module cbm_res_reg
   import cbm_pkg::*;
#(
   parameter int W = RES_W
) (
   input  wire logic         clk_sys, // system clock
   input  wire logic         rst,     // async reset
   input  wire logic         clk_en,  // freeze when low
   input  wire logic         load,    // capture strobe
   input  wire logic [W-1:0] din,     // new value
   output logic      [W-1:0] dout     // held value
);
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         dout <= '0;
      end else if (clk_en && load) begin
         dout <= din;
      end
   end
endmodule : cbm_res_reg
`default_nettype wire

//--- cbm_beam_ctrl.sv
// crt beam measurement and average beam limiter sequencing, top level
// assumes line/field strobes from display sync, pdm sense stream, all sync to clk_sys
`timescale 1ns/10ps
`default_nettype none
module cbm_beam_ctrl
   import cbm_pkg::*;
(
   input  wire logic               clk_sys,        // 25 MHz clock
   input  wire logic               rst,            // async reset, high
   input  wire logic               clk_en,         // freeze when low
   input  wire logic               vsync,          // field start pulse
   input  wire logic               hsync,          // line start pulse
   input  wire logic               active_line,    // line is in active picture
   input  wire logic               active_px,      // active pixel time in line
   input  wire logic               small_win,      // small horizontal window time
   input  wire logic               sense_pdm,      // sense bit stream
   input  wire logic [9:0]         tube_start_line,// tube start line
   input  wire logic               offset_check,   // offset-check mode
   input  wire logic [7:0]         meas_bright,    // brightness during tube meas
   input  wire logic [7:0]         norm_bright,    // normal brightness
   input  wire logic               pic_enable,     // pulse: arm picture meas
   input  wire logic [9:0]         pic_first_line, // picture first line
   input  wire logic [9:0]         pic_last_line,  // picture last line
   input  wire logic               pic_bw_large,   // picture bandwidth select
   input  wire logic               pic_large_win,  // picture large window select, no effect
   input  wire logic [7:0]         abl_thresh,     // limiter threshold
   input  wire logic [ATT_W-1:0]   abl_min_att,    // attenuation lower bound
   input  wire logic [ATT_W-1:0]   white_drive_r,  // white drive gain red
   input  wire logic [ATT_W-1:0]   white_drive_g,  // white drive gain green
   input  wire logic [ATT_W-1:0]   white_drive_b,  // white drive gain blue
   input  wire logic [CUT_W-1:0]   cutoff_r,       // cutoff code red
   input  wire logic [CUT_W-1:0]   cutoff_g,       // cutoff code green
   input  wire logic [CUT_W-1:0]   cutoff_b,       // cutoff code blue
   input  wire logic [CUT_W-1:0]   blank_level,    // blanking level
   input  wire logic [RGB_W-1:0]   pic_r,          // digital picture red
   input  wire logic [RGB_W-1:0]   pic_g,          // digital picture green
   input  wire logic [RGB_W-1:0]   pic_b,          // digital picture blue
   input  wire logic [2:0]         pic_prio,       // digital picture priority
   input  wire logic [2:0]         ext_prio,       // external rgb priority
   input  wire logic               ext_valid,      // external rgb present
   input  wire logic               rd_cut_b,       // pulse: blue cutoff read
   output logic [RES_W-1:0]        res_cut_r,      // cutoff red result
   output logic [RES_W-1:0]        res_cut_g,      // cutoff green result
   output logic [RES_W-1:0]        res_cut_b,      // cutoff blue result
   output logic [RES_W-1:0]        res_white,      // white drive result
   output logic [1:0]              res_white_col,  // colour of white result
   output logic [RES_W-1:0]        res_pic_min,    // picture minimum
   output logic [RES_W-1:0]        res_pic_max,    // picture maximum
   output logic                    pic_done,       // picture set complete
   output logic                    tube_busy,      // tube sequence running
   output logic                    abl_offset_adj, // limiter offset adjust line
   output logic [ATT_W-1:0]        gain_r,         // digital drive red
   output logic [ATT_W-1:0]        gain_g,         // digital drive green
   output logic [ATT_W-1:0]        gain_b,         // digital drive blue
   output logic [ATT_W-1:0]        ext_contrast,   // analog contrast gain
   output logic [7:0]              bright_out,     // brightness in use
   output logic                    zero_drive,     // cutoff/white forced zero
   output logic                    ext_on_top,     // external rgb overlays
   output logic [RGB_W-1:0]        rgb_r,          // 10-bit output red
   output logic [RGB_W-1:0]        rgb_g,          // 10-bit output green
   output logic [RGB_W-1:0]        rgb_b           // 10-bit output blue
);
   // =========================================================
   // line counter
   logic [9:0]   line_q;
   cbm_tube_st_t ts_q;
   cbm_pic_st_t  ps_q;
   logic         tube_req_q;
   logic [1:0]   white_col_q;
   logic [1:0]   rec_q;
   logic         conv_start;
   logic         conv_large;
   logic         conv_done;
   logic [RES_W-1:0] conv_res;
   logic         win_q;
   logic         tube_meas;
   logic [9:0]   line_nx;
   logic         start_hit;

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         line_q <= '0;
      end else if (clk_en) begin
         if (vsync) begin
            line_q <= '0;
         end else if (hsync) begin
            line_q <= line_q + 1'b1;
         end
      end
   end

   // line that this hsync opens
   assign line_nx   = vsync ? '0 : line_q + 1'b1;
   assign start_hit = hsync && (line_nx == tube_start_line);

   // =========================================================
   // converter, shared by tube and picture sets
   // tube set always runs in small bandwidth, over the 475-cycle window started at hsync
   assign tube_meas  = (ts_q == TS_CUT_R) || (ts_q == TS_CUT_G) ||
                       (ts_q == TS_CUT_B) || (ts_q == TS_WHITE) || (ts_q == TS_OFFSET);
   assign conv_large = tube_meas ? 1'b0 : pic_bw_large;
   assign conv_start = clk_en && hsync &&
                       (tube_meas || ((ps_q == PS_RUN) && active_line));

   cbm_pdm_conv u_conv (
      .clk_sys  (clk_sys),
      .rst      (rst),
      .clk_en   (clk_en),
      .pdm_bit  (sense_pdm),
      .start    (conv_start),
      .bw_large (conv_large),
      .done     (conv_done),
      .result   (conv_res)
   );

   // =========================================================
   // tube sequence: in blanking, starting on the programmed line
   // a line's measurement is valid only if its window ends before the next hsync
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         tube_req_q <= 1'b1;
      end else if (clk_en) begin
         if (rd_cut_b) begin
            tube_req_q <= 1'b1;
         end else if (ts_q == TS_WAIT && start_hit) begin
            tube_req_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         ts_q        <= TS_IDLE;
         white_col_q <= 2'h0;
         rec_q       <= 2'h0;
      end else if (clk_en) begin
         case (ts_q)
            TS_IDLE: begin
               if (vsync && tube_req_q) begin
                  ts_q <= TS_WAIT;
               end
            end
            TS_WAIT: begin
               if (start_hit) begin
                  ts_q <= TS_OFFSET;
               end
            end
            TS_OFFSET: begin
               // covers start line and start+1; red follows two lines later
               if (hsync && line_nx == tube_start_line + RED_CUT_OFS) begin
                  ts_q <= TS_CUT_R;
               end
            end
            TS_CUT_R: if (hsync) ts_q <= TS_CUT_G;
            TS_CUT_G: if (hsync) ts_q <= TS_CUT_B;
            TS_CUT_B: if (hsync) ts_q <= TS_WHITE;
            TS_WHITE: begin
               if (hsync) begin
                  ts_q  <= TS_RECOVER;
                  rec_q <= RECOVER_LINES[1:0] - 1'b1;
                  white_col_q <= (white_col_q == 2'h2) ? 2'h0 : white_col_q + 1'b1;
               end
            end
            TS_RECOVER: begin
               if (hsync) begin
                  if (rec_q == 2'h0) begin
                     ts_q <= TS_IDLE;
                  end else begin
                     rec_q <= rec_q - 1'b1;
                  end
               end
            end
            default: ts_q <= TS_IDLE;
         endcase
      end
   end

   // offset adjust on start line, i.e. two lines before red cutoff
   assign abl_offset_adj = (ts_q == TS_OFFSET) && (line_q == tube_start_line);
   assign tube_busy      = (ts_q != TS_IDLE) && (ts_q != TS_WAIT);
   assign zero_drive     = tube_meas && offset_check && (ts_q != TS_OFFSET);

   // tags the running conversion as tube or picture
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         win_q <= 1'b0;
      end else if (clk_en) begin
         if (conv_start) win_q <= tube_meas;
      end
   end

   logic ld_r;
   logic ld_g;
   logic ld_b;
   logic ld_w;
   assign ld_r = conv_done && (ts_q == TS_CUT_R);
   assign ld_g = conv_done && (ts_q == TS_CUT_G);
   assign ld_b = conv_done && (ts_q == TS_CUT_B);
   assign ld_w = conv_done && (ts_q == TS_WHITE);

   cbm_res_reg u_cut_r (.clk_sys(clk_sys), .rst(rst), .clk_en(clk_en),
                        .load(ld_r), .din(conv_res), .dout(res_cut_r));
   cbm_res_reg u_cut_g (.clk_sys(clk_sys), .rst(rst), .clk_en(clk_en),
                        .load(ld_g), .din(conv_res), .dout(res_cut_g));
   cbm_res_reg u_cut_b (.clk_sys(clk_sys), .rst(rst), .clk_en(clk_en),
                        .load(ld_b), .din(conv_res), .dout(res_cut_b));
   cbm_res_reg u_white (.clk_sys(clk_sys), .rst(rst), .clk_en(clk_en),
                        .load(ld_w), .din(conv_res), .dout(res_white));

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         res_white_col <= 2'h0;
      end else if (clk_en && ts_q == TS_WHITE && hsync) begin
         res_white_col <= white_col_q;
      end
   end

   // =========================================================
   // picture measurement: armed by software, runs over a line range
   logic [RES_W-1:0] min_d;
   logic [RES_W-1:0] max_d;
   logic             pic_ld;
   logic             pic_first_q;

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         ps_q        <= PS_IDLE;
         pic_done    <= 1'b0;
         pic_first_q <= 1'b1;
      end else if (clk_en) begin
         case (ps_q)
            PS_IDLE: begin
               if (pic_enable) begin
                  ps_q     <= PS_ARMED;
                  pic_done <= 1'b0;
               end
            end
            PS_ARMED: begin
               if (vsync) begin
                  ps_q        <= PS_RUN;
                  pic_first_q <= 1'b1;
               end
            end
            PS_RUN: begin
               if (pic_ld) begin
                  pic_first_q <= 1'b0;
               end
               if (hsync && line_q > pic_last_line) begin
                  ps_q     <= PS_IDLE;
                  pic_done <= 1'b1;
               end
            end
            default: ps_q <= PS_IDLE;
         endcase
      end
   end

   assign pic_ld = conv_done && !win_q && (ps_q == PS_RUN) &&
                   (line_q >= pic_first_line) && (line_q <= pic_last_line) &&
                   (pic_large_win || small_win || 1'b1);
   assign min_d  = (pic_first_q || conv_res < res_pic_min) ? conv_res : res_pic_min;
   assign max_d  = (pic_first_q || conv_res > res_pic_max) ? conv_res : res_pic_max;

   cbm_res_reg u_pmin (.clk_sys(clk_sys), .rst(rst), .clk_en(clk_en),
                       .load(pic_ld), .din(min_d), .dout(res_pic_min));
   cbm_res_reg u_pmax (.clk_sys(clk_sys), .rst(rst), .clk_en(clk_en),
                       .load(pic_ld), .din(max_d), .dout(res_pic_max));

   // =========================================================
   // average beam limiter: iir over active picture, excess reduces gain
   logic [RES_W+ABL_SHIFT-1:0] avg_q;
   logic [RES_W-1:0]           avg;
   logic [ATT_W-1:0]           att_q;
   logic [ATT_W-1:0]           att_raw;
   logic [RES_W-1:0]           excess;
   logic                       abl_off;

   assign avg     = avg_q[RES_W+ABL_SHIFT-1:ABL_SHIFT];
   assign excess  = (avg > abl_thresh) ? avg - abl_thresh : '0;
   assign att_raw = ATT_UNITY - excess;
   assign abl_off = (ts_q != TS_IDLE) && (ts_q != TS_WAIT);

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         avg_q <= '0;
      end else if (clk_en && active_line && active_px) begin
         avg_q <= avg_q - (avg_q >> ABL_SHIFT)
                  + ({{(ABL_SHIFT+RES_W-1){1'b0}}, sense_pdm} << RES_W);
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         att_q <= ATT_UNITY;
      end else if (clk_en) begin
         att_q <= (att_raw < abl_min_att) ? abl_min_att : att_raw;
      end
   end

   function automatic logic [ATT_W-1:0] scale(input logic [ATT_W-1:0] a,
                                              input logic [ATT_W-1:0] b);
      logic [2*ATT_W-1:0] p;
      p = a * b;
      return p[2*ATT_W-1:ATT_W];
   endfunction : scale

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         gain_r       <= '0;
         gain_g       <= '0;
         gain_b       <= '0;
         ext_contrast <= ATT_UNITY;
         bright_out   <= '0;
      end else if (clk_en) begin
         gain_r       <= abl_off ? white_drive_r : scale(white_drive_r, att_q);
         gain_g       <= abl_off ? white_drive_g : scale(white_drive_g, att_q);
         gain_b       <= abl_off ? white_drive_b : scale(white_drive_b, att_q);
         ext_contrast <= abl_off ? ATT_UNITY : att_q;
         bright_out   <= abl_off ? meas_bright : norm_bright;
      end
   end

   // =========================================================
   // output path: priority select, then cutoff plus blanking
   logic             ext_wins;
   logic [RGB_W:0]   sum_r;
   logic [RGB_W:0]   sum_g;
   logic [RGB_W:0]   sum_b;
   logic [CUT_W:0]   ofs_r;
   logic [CUT_W:0]   ofs_g;
   logic [CUT_W:0]   ofs_b;

   // lower number is higher priority; external blanks digital when it wins
   assign ext_wins = ext_valid && (ext_prio < pic_prio);
   assign ofs_r = zero_drive ? '0 : {1'b0, cutoff_r} + {1'b0, blank_level};
   assign ofs_g = zero_drive ? '0 : {1'b0, cutoff_g} + {1'b0, blank_level};
   assign ofs_b = zero_drive ? '0 : {1'b0, cutoff_b} + {1'b0, blank_level};
   assign sum_r = (ext_wins ? '0 : {1'b0, pic_r}) + (RGB_W+1)'(ofs_r);
   assign sum_g = (ext_wins ? '0 : {1'b0, pic_g}) + (RGB_W+1)'(ofs_g);
   assign sum_b = (ext_wins ? '0 : {1'b0, pic_b}) + (RGB_W+1)'(ofs_b);

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         rgb_r      <= '0;
         rgb_g      <= '0;
         rgb_b      <= '0;
         ext_on_top <= 1'b0;
      end else if (clk_en) begin
         // clip to full scale rather than wrap
         rgb_r      <= sum_r[RGB_W] ? '1 : sum_r[RGB_W-1:0];
         rgb_g      <= sum_g[RGB_W] ? '1 : sum_g[RGB_W-1:0];
         rgb_b      <= sum_b[RGB_W] ? '1 : sum_b[RGB_W-1:0];
         ext_on_top <= ext_wins;
      end
   end
endmodule : cbm_beam_ctrl
`default_nettype wire

//--- cbm_sense_model.sv
// sense circuit model: pulse-density stream of a chosen density
// assumes the bench sets density per line; no reset of its own
`timescale 1ns/10ps
`default_nettype none
module cbm_sense_model (
   input  wire logic       clk_sys,  // system clock
   input  wire logic [7:0] density,  // ones per 256 cycles
   output logic            sense_pdm // sense bit stream
);
   // =====================================================
   // first-order delta-sigma, changes off the sampling edge
   logic [8:0] acc_q = 9'h000;
   always @(negedge clk_sys) begin
      acc_q <= {1'b0, acc_q[7:0]} + {1'b0, density};
   end
   assign sense_pdm = acc_q[8];
endmodule : cbm_sense_model
`default_nettype wire

//--- cbm_beam_ctrl_assertions.sv
// port checker for the beam measurement top
// sees top ports only; bound after the module
`timescale 1ns/10ps
`default_nettype none
module cbm_beam_ctrl_assertions
   import cbm_pkg::*;
(
   input wire logic             clk_sys,        // clock
   input wire logic             rst,            // reset
   input wire logic             offset_check,   // mode
   input wire logic [7:0]       meas_bright,    // tube brightness
   input wire logic [ATT_W-1:0] abl_min_att,    // floor
   input wire logic             pic_enable,     // arm
   input wire logic             zero_drive,     // forced zero
   input wire logic             tube_busy,      // tube sequence
   input wire logic             abl_offset_adj, // adjust line
   input wire logic [7:0]       bright_out,     // brightness
   input wire logic [ATT_W-1:0] ext_contrast,   // contrast
   input wire logic [1:0]       res_white_col,  // white colour
   input wire logic [RES_W-1:0] res_white,      // white result
   input wire logic [RES_W-1:0] res_cut_b,      // blue result
   input wire logic             pic_done        // picture done
);
   // =====================================================
   // properties
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   a_zero_in_check: assert property (zero_drive |-> offset_check && tube_busy)
      else $error("zero drive outside offset check");
   a_adj_in_tube: assert property (abl_offset_adj |-> tube_busy)
      else $error("offset adjust outside tube sequence");
   a_bright_subst: assert property (tube_busy && $past(tube_busy, 2) |-> bright_out == meas_bright)
      else $error("tube brightness not substituted");
   a_contrast_floor: assert property (ext_contrast >= abl_min_att)
      else $error("attenuation below floor");
   a_white_col_cycle: assert property ($changed(res_white_col) |->
      res_white_col == ($past(res_white_col) == 2'h2 ? 2'h0 : $past(res_white_col) + 2'h1))
      else $error("white colour out of order");
   a_pic_done_hold: assert property (pic_done && !pic_enable |=> pic_done)
      else $error("picture done dropped");
   a_cut_b_hold: assert property ($changed(res_cut_b) |-> $past(tube_busy))
      else $error("blue result moved outside tube");
   a_white_hold: assert property ($changed(res_white) |-> $past(tube_busy))
      else $error("white result moved outside tube");
endmodule : cbm_beam_ctrl_assertions
bind cbm_beam_ctrl cbm_beam_ctrl_assertions u_cbm_beam_ctrl_assertions (.clk_sys, .rst,
   .offset_check, .meas_bright, .abl_min_att, .pic_enable, .zero_drive, .tube_busy,
   .abl_offset_adj, .bright_out, .ext_contrast, .res_white_col, .res_white, .res_cut_b, .pic_done);
`default_nettype wire

//--- test_cbm_beam_ctrl.sv
// self-checking bench for the beam measurement block
// bench makes line and field strobes; sense stream from the model
`timescale 1ns/10ps
`default_nettype none
module test_cbm_beam_ctrl;
   import cbm_pkg::*;
   localparam int LINE = 520; // lines must outlast the 475-cycle window
   localparam int S = 3;
   logic clk_sys, rst, vsync, hsync, active_line, active_px, small_win, sense_pdm, offset_check;
   logic pic_enable, pic_bw_large, pic_large_win, ext_valid, rd_cut_b, pic_done, tube_busy;
   logic abl_offset_adj, zero_drive, ext_on_top;
   logic [9:0] tube_start_line, pic_first_line, pic_last_line, pic_r, pic_g, pic_b;
   logic [9:0] rgb_r, rgb_g, rgb_b;
   logic [8:0] cutoff_r, cutoff_g, cutoff_b, blank_level;
   logic [7:0] meas_bright, norm_bright, abl_thresh, abl_min_att, dens, bright_out, ext_contrast;
   logic [7:0] white_drive_r, white_drive_g, white_drive_b, gain_r, gain_g, gain_b;
   logic [7:0] res_cut_r, res_cut_g, res_cut_b, res_white, res_pic_min, res_pic_max, pv[4], cur[4];
   logic [2:0] pic_prio, ext_prio;
   logic [1:0] res_white_col;
   int         n_mismatch, n_compared, nseq, la, bl, zs, lc[4];
   cbm_beam_ctrl u_cbm_beam_ctrl (.clk_sys, .rst, .clk_en(1'b1), .vsync, .hsync, .active_line,
      .active_px, .small_win, .sense_pdm, .tube_start_line, .offset_check, .meas_bright,
      .norm_bright, .pic_enable, .pic_first_line, .pic_last_line, .pic_bw_large, .pic_large_win,
      .abl_thresh, .abl_min_att, .white_drive_r, .white_drive_g, .white_drive_b, .cutoff_r,
      .cutoff_g, .cutoff_b, .blank_level, .pic_r, .pic_g, .pic_b, .pic_prio, .ext_prio,
      .ext_valid, .rd_cut_b, .res_cut_r, .res_cut_g, .res_cut_b, .res_white, .res_white_col,
      .res_pic_min, .res_pic_max, .pic_done, .tube_busy, .abl_offset_adj, .gain_r, .gain_g,
      .gain_b, .ext_contrast, .bright_out, .zero_drive, .ext_on_top, .rgb_r, .rgb_g, .rgb_b);
   cbm_sense_model u_cbm_sense_model (.clk_sys, .density(dens), .sense_pdm);
   // =====================================================
   // tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic wrap_up;
      if (n_mismatch == 0 && n_compared > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : wrap_up
   // one field of 16 lines; records on which line each result moved
   task automatic field(input int f);
      lc = '{-1, -1, -1, -1};
      la = -1;
      bl = -1;
      zs = 0;
      for (int ln = 0; ln < 16; ln++) begin
         for (int c = 0; c < LINE; c++) begin
            @(negedge clk_sys);
            vsync = ln == 0 && c == 0;
            hsync = c == 0;
            active_line = ln > 12;
            active_px = active_line && c > 40 && c < 500;
            small_win = c > 100 && c < 300;
            pic_enable = f == 2 && ln == 15 && c == 10;
            rd_cut_b = f != 1 && ln == 15 && c == 20;
            if (c == 0) begin
               {pic_prio, ext_prio, ext_valid, pic_bw_large, pic_large_win, dens} = $urandom;
               dens = {6'(ln * 3 + f * 10), dens[1:0]}; // results move in every field that runs the tube sequence
               {white_drive_r, white_drive_g, white_drive_b, cutoff_r, cutoff_g} = $urandom;
               {cutoff_b, blank_level, pic_r} = $urandom;
               {pic_g, pic_b, abl_thresh} = $urandom;
            end
            cur = '{res_cut_r, res_cut_g, res_cut_b, res_white};
            for (int k = 0; k < 4; k++)
               if (cur[k] !== pv[k]) begin
                  lc[k] = ln;
                  pv[k] = cur[k];
               end
            if (tube_busy === 1'b1 && c > 0) bl = ln;
            if (abl_offset_adj === 1'b1 && c > 0) la = ln;
            if (zero_drive === 1'b1) zs = 1;
            if (tube_busy === 1'b1 && c == 300) chk(bright_out, meas_bright);
            if (tube_busy === 1'b1 && c == 300) chk(gain_r, white_drive_r);
            if (c == 5) chk(ext_on_top, ext_valid && ext_prio < pic_prio);
         end
      end
   endtask : field
   // =====================================================
   // clock and main sequence
   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end
   initial begin
      rst = 1'b1;
      {vsync, hsync, active_line, active_px, small_win, offset_check, pic_enable, rd_cut_b} = '0;
      {pic_bw_large, pic_large_win, ext_valid, pic_prio, ext_prio, dens, abl_thresh} = '0;
      {white_drive_r, white_drive_g, white_drive_b, cutoff_r, cutoff_g, cutoff_b} = '0;
      {blank_level, pic_r, pic_g, pic_b, meas_bright, norm_bright} = '0;
      tube_start_line = 10'h003;
      pic_first_line = 10'h00d;
      pic_last_line = 10'h00d;
      abl_min_att = 8'h40;
      pv = '{8'h00, 8'h00, 8'h00, 8'h00};
      void'($urandom(32'hadd35e4a));
      repeat (12) @(posedge clk_sys);
      @(negedge clk_sys);
      rst = 1'b0;
      for (int f = 0; f < 6; f++) begin
         offset_check = f == 5;
         {meas_bright, norm_bright} = $urandom;
         field(f);
         if (f == 2) chk(bl, -1);
         else begin
            chk(la, S);
            chk(lc[0], la + 2);
            chk(lc[1], lc[0] + 1);
            chk(lc[2], lc[0] + 2);
            chk(lc[3], lc[0] + 3);
            chk(bl, lc[3] + 3);
            chk(zs, f == 5);
            if (f < 5) chk(res_white_col, nseq % 3);
            nseq++;
         end
         if (f == 3) chk(pic_done, 1);
         if (f == 3) chk(res_pic_min <= res_pic_max, 1);
      end
      wrap_up;
   end
endmodule : test_cbm_beam_ctrl
`default_nettype wire
